// ### core_pipe_defs.svh
// Constants for the five-stage core pipeline control
// Function
// - Execute 32-bit and compressed 16-bit instructions
// - Separate instruction and data memory interfaces
// - Five stages: fetch, decode, execute, memory, write
// - Fully interlocked; load-use costs one cycle; the interlock compares only the decoded rn and rm with the load list
// - Data abort restores base register value
// - Stored program counter equals instruction address plus 12
// - Bits 27:25 011 with bit 4 undefined
// - Unassigned extension space encodings are undefined
// - New fetch as instruction enters execute
// - Fetch abort taken only in execute
`ifndef CORE_PIPE_DEFS_SVH
`define CORE_PIPE_DEFS_SVH

`define RESET_PC      32'h0000_0000
`define VEC_UNDEF     32'h0000_0004
`define VEC_PABT      32'h0000_000c
`define VEC_DABT      32'h0000_0010
`define PC_STORE_OFS  32'h0000_000c
`define STEP_WORD     32'h0000_0004
`define STEP_HALF     32'h0000_0002
`define PC_REG        4'hf
`define HALF_SEL_BIT  1

`endif

// ### core_pipe_pkg.sv
// Types used by the pipeline control; its decoder does not use them
package core_pipe_pkg;

  typedef enum logic [0:0] {
    CTL_START,
    CTL_RUN
  } ctrl_e;

  typedef struct packed {
    ctrl_e       ctl;
    logic [31:0] fetch_pc;
    logic        pend_v;
    logic [31:0] pend_pc;
    logic        pend_compact;
    logic        id_v;
    logic [31:0] id_instr;
    logic [31:0] id_pc;
    logic        id_abt;
    logic        id_compact;
    logic        ex_v;
    logic [31:0] ex_pc;
    logic        ex_abt;
    logic        ex_undef;
    logic        ex_load;
    logic        ex_store;
    logic [15:0] ex_list;
    logic [3:0]  ex_rn;
    logic        ex_bwb;
    logic        ex_spc;
    logic        mem_v;
    logic        mem_load;
    logic        mem_store;
    logic [15:0] mem_list;
    logic [3:0]  mem_rn;
    logic        mem_bwb;
    logic [31:0] mem_old_base;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        wb_load_en;
    logic [15:0] wb_list;
    logic        wb_bwb;
    logic [3:0]  wb_rn;
    logic        rst_v;
    logic [3:0]  rst_reg;
    logic [31:0] rst_val;
    logic        exc_v;
    logic [31:0] exc_vec;
  } pipe_state_s;

endpackage

// ### instr_decode.sv
// Decode of register use, memory class and undefined encodings
`include "core_pipe_defs.svh"
module instr_decode (
  // Instruction in decode
  input  wire logic [31:0] instr,
  input  wire logic        compact,
  // Decoded fields
  output logic             is_load,
  output logic             is_store,
  output logic [15:0]      load_list,
  output logic [3:0]       rn,
  output logic [3:0]       rm,
  output logic             use_rn,
  output logic             use_rm,
  output logic             base_wb,
  output logic             stores_pc,
  output logic             undef
);

  // One-hot register mask
  function automatic logic [15:0] onehot(input logic [3:0] r);
    logic [15:0] m;
    m = 16'h0000;
    m[r] = 1'b1;
    return m;
  endfunction

  // Field extraction and class decode
  always_comb begin
    is_load   = 1'b0;
    is_store  = 1'b0;
    load_list = 16'h0000;
    rn        = instr[19:16];
    rm        = instr[3:0];
    use_rn    = 1'b1;
    use_rm    = 1'b0;
    base_wb   = 1'b0;
    stores_pc = 1'b0;
    undef     = 1'b0;
    if (compact) begin
      rn     = {1'b0, instr[5:3]};
      rm     = {1'b0, instr[8:6]};
      use_rm = 1'b1;
      casez (instr[15:11])
        5'b01101: begin
          is_load   = 1'b1;
          use_rm    = 1'b0;
          load_list = onehot({1'b0, instr[2:0]});
        end
        5'b01100: begin
          is_store = 1'b1;
          use_rm   = 1'b0;
        end
        default: ;
      endcase
    end else begin
      casez (instr[27:20])
        8'b01??_????: begin
          if (instr[25] && instr[4]) begin
            undef = 1'b1;
          end else begin
            use_rm    = instr[25];
            is_load   = instr[20];
            is_store  = !instr[20];
            base_wb   = !instr[24] || instr[21];
            stores_pc = !instr[20] && (instr[15:12] == `PC_REG);
            load_list = instr[20] ? onehot(instr[15:12]) : 16'h0000;
          end
        end
        8'b100?_????: begin
          is_load   = instr[20];
          is_store  = !instr[20];
          base_wb   = instr[21];
          stores_pc = !instr[20] && instr[15];
          load_list = instr[20] ? instr[15:0] : 16'h0000;
        end
        8'b1100_0?0?: undef = 1'b1;
        8'b0001_0??0: begin
          if (instr[7:4] == 4'h9) begin
            undef     = (instr[21:20] != 2'h0);
            is_load   = !undef;
            is_store  = !undef;
            use_rm    = 1'b1;
            load_list = undef ? 16'h0000 : onehot(instr[15:12]);
          end else if (!(instr[7] && instr[4])) begin
            undef = !((instr[7:4] == 4'h0) ||
                      (instr[22:21] == 2'h1 && instr[7:4] == 4'h1));
            use_rm = 1'b1;
          end else if (instr[6]) begin
            undef = 1'b1;
          end else begin
            // Halfword store, pre-indexed, offset subtracted
            use_rm    = !instr[22];
            is_store  = 1'b1;
            base_wb   = instr[21];
            stores_pc = (instr[15:12] == `PC_REG);
          end
        end
        default: begin
          use_rm = !instr[25];
          if (instr[27:25] == 3'h0 && instr[7] && instr[4]) begin
            if (instr[6:5] == 2'h0) begin
              undef = (instr[24] || instr[23:22] == 2'h1);
              use_rm = 1'b1;
            end else if (!instr[20] && instr[6]) begin
              undef = 1'b1;
            end else begin
              use_rm    = !instr[22];
              is_load   = instr[20];
              is_store  = !instr[20];
              base_wb   = !instr[24] || instr[21];
              stores_pc = !instr[20] && (instr[15:12] == `PC_REG);
              load_list = instr[20] ? onehot(instr[15:12]) : 16'h0000;
            end
          end
        end
      endcase
    end
  end

endmodule

// ### core_pipe_ctrl.sv
// Five-stage pipeline control with interlock and exception steering
`include "core_pipe_defs.svh"
module core_pipe_ctrl (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Mode
  input  wire logic        compact_mode,
  // Instruction interface
  output logic             fetch_req,
  output logic [31:0]      fetch_addr,
  input  wire logic [31:0] instr_rdata,
  input  wire logic        fetch_abort_in,
  // Datapath values for the instruction in execute
  input  wire logic [31:0] ex_addr_in,
  input  wire logic [31:0] ex_store_data_in,
  input  wire logic [31:0] ex_base_in,
  // Data interface
  output logic             dmem_req,
  output logic             dmem_write,
  output logic [31:0]      dmem_addr,
  output logic [31:0]      dmem_wdata,
  input  wire logic        dmem_abort_in,
  // Pipeline status
  output logic             load_use_stall,
  output logic             ex_valid,
  output logic [31:0]      ex_pc,
  // Write-back control
  output logic             wb_load_en,
  output logic [15:0]      wb_load_list,
  output logic             wb_base_en,
  output logic [3:0]       wb_base_reg,
  // Base restore after data abort
  output logic             base_restore_en,
  output logic [3:0]       base_restore_reg,
  output logic [31:0]      base_restore_val,
  // Exception entry
  output logic             exc_take,
  output logic [31:0]      exc_vector
);

  core_pipe_pkg::pipe_state_s s_q;
  core_pipe_pkg::pipe_state_s s_d;

  logic        d_load;
  logic        d_store;
  logic [15:0] d_list;
  logic [3:0]  d_rn;
  logic [3:0]  d_rm;
  logic        d_use_rn;
  logic        d_use_rm;
  logic        d_bwb;
  logic        d_spc;
  logic        d_undef;
  logic        hazard;
  logic        dabt;
  logic        ex_exc;
  logic        flush;
  logic        stall;
  logic        accept;
  logic        running;
  logic [31:0] fetched;

  // Source register caught by an outstanding load
  function automatic logic reg_hit(input logic [15:0] list,
                                   input logic [3:0]  r,
                                   input logic        used);
    return used && list[r];
  endfunction

  // Decoder on the instruction held in decode
  instr_decode u_dec (
    .instr     (s_q.id_instr),
    .compact   (s_q.id_compact),
    .is_load   (d_load),
    .is_store  (d_store),
    .load_list (d_list),
    .rn        (d_rn),
    .rm        (d_rm),
    .use_rn    (d_use_rn),
    .use_rm    (d_use_rm),
    .base_wb   (d_bwb),
    .stores_pc (d_spc),
    .undef     (d_undef)
  );

  // Hazard, abort and flow terms
  always_comb begin
    running = (s_q.ctl == core_pipe_pkg::CTL_RUN);
    hazard  = s_q.id_v && s_q.ex_v && s_q.ex_load &&
              (reg_hit(s_q.ex_list, d_rn, d_use_rn) ||
               reg_hit(s_q.ex_list, d_rm, d_use_rm));
    // abort of the access in memory
    dabt    = s_q.mem_v && (s_q.mem_load || s_q.mem_store) &&
              dmem_abort_in;
    // fetch abort acts only in execute
    ex_exc  = s_q.ex_v && (s_q.ex_abt || s_q.ex_undef) && !dabt;
    flush   = dabt || ex_exc;
    stall   = hazard && !flush;
    accept  = s_q.pend_v && running && !stall && !flush;
    // fetch as decode moves into execute
    fetch_req = running && !stall && !flush;
    fetched = (s_q.pend_compact && s_q.pend_pc[`HALF_SEL_BIT]) ?
              {16'h0000, instr_rdata[31:16]} :
              (s_q.pend_compact ? {16'h0000, instr_rdata[15:0]} :
               instr_rdata);
  end

  // Next state of every stage
  always_comb begin
    s_d       = s_q;
    s_d.rst_v = 1'b0;
    s_d.exc_v = 1'b0;
    case (s_q.ctl)
      core_pipe_pkg::CTL_START: s_d.ctl = core_pipe_pkg::CTL_RUN;
      core_pipe_pkg::CTL_RUN:   s_d.ctl = core_pipe_pkg::CTL_RUN;
      default:                  s_d.ctl = core_pipe_pkg::CTL_START;
    endcase
    // instruction side runs beside data side
    s_d.pend_v = fetch_req;
    if (fetch_req) begin
      s_d.pend_pc    = s_q.fetch_pc;
      s_d.pend_compact = compact_mode;
      s_d.fetch_pc   = s_q.fetch_pc +
                       (compact_mode ? `STEP_HALF : `STEP_WORD);
    end else if (s_q.pend_v && !accept && !flush) begin
      s_d.fetch_pc = s_q.pend_pc;  // Word dropped by stall, refetch
    end
    s_d.wb_load_en = s_q.mem_v && s_q.mem_load && !dabt;
    s_d.wb_list    = s_q.mem_list;
    s_d.wb_bwb     = s_q.mem_v && s_q.mem_bwb && !dabt;
    s_d.wb_rn      = s_q.mem_rn;
    s_d.rst_v   = dabt && s_q.mem_bwb;
    s_d.rst_reg = s_q.mem_rn;
    s_d.rst_val = s_q.mem_old_base;
    s_d.mem_v        = s_q.ex_v && !flush;
    s_d.mem_load     = s_q.ex_load;
    s_d.mem_store    = s_q.ex_store;
    s_d.mem_list     = s_q.ex_list;
    s_d.mem_rn       = s_q.ex_rn;
    s_d.mem_bwb      = s_q.ex_bwb;
    s_d.mem_old_base = ex_base_in;
    s_d.mem_addr     = ex_addr_in;
    s_d.mem_wdata    = s_q.ex_spc ? (s_q.ex_pc + `PC_STORE_OFS) :
                       ex_store_data_in;
    if (flush || stall) begin
      s_d.ex_v = 1'b0;
    end else begin
      s_d.ex_v     = s_q.id_v;
      s_d.ex_pc    = s_q.id_pc;
      s_d.ex_abt   = s_q.id_abt;
      s_d.ex_undef = d_undef && !s_q.id_abt;
      s_d.ex_load  = d_load;
      s_d.ex_store = d_store;
      s_d.ex_list  = d_list;
      s_d.ex_rn    = d_rn;
      s_d.ex_bwb   = d_bwb;
      s_d.ex_spc   = d_spc;
    end
    if (flush) begin
      s_d.id_v = 1'b0;
    end else if (!stall) begin
      s_d.id_v     = accept;
      s_d.id_instr = fetched;
      s_d.id_pc    = s_q.pend_pc;
      s_d.id_abt   = fetch_abort_in;
      s_d.id_compact = s_q.pend_compact;
    end
    if (flush) begin
      s_d.exc_v    = 1'b1;
      s_d.exc_vec  = dabt ? `VEC_DABT :
                     (s_q.ex_abt ? `VEC_PABT : `VEC_UNDEF);
      s_d.fetch_pc = s_d.exc_vec;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.ctl      <= core_pipe_pkg::CTL_START;
      s_q.fetch_pc <= `RESET_PC;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign fetch_addr       = s_q.fetch_pc;
  assign dmem_req         = s_q.mem_v && (s_q.mem_load || s_q.mem_store);
  assign dmem_write       = s_q.mem_v && s_q.mem_store;
  assign dmem_addr        = s_q.mem_addr;
  assign dmem_wdata       = s_q.mem_wdata;
  assign load_use_stall   = stall;
  assign ex_valid         = s_q.ex_v;
  assign ex_pc            = s_q.ex_pc;
  assign wb_load_en       = s_q.wb_load_en;
  assign wb_load_list     = s_q.wb_list;
  assign wb_base_en       = s_q.wb_bwb;
  assign wb_base_reg      = s_q.wb_rn;
  assign base_restore_en  = s_q.rst_v;
  assign base_restore_reg = s_q.rst_reg;
  assign base_restore_val = s_q.rst_val;
  assign exc_take         = s_q.exc_v;
  assign exc_vector       = s_q.exc_vec;

  // Checks on stage flow and exception steering
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence seq_enter_mem;
    s_q.ex_v && !flush ##1 s_q.mem_v;
  endsequence

  sequence seq_no_abort;
    !dabt;
  endsequence

  AST_STALL_BUBBLE: assert property (stall |=> !s_q.ex_v)
    else $error("stall did not bubble execute");
  AST_STALL_HOLD: assert property (stall |=> s_q.id_v &&
      s_q.id_instr == $past(s_q.id_instr))
    else $error("decode changed during stall");
  AST_ONE_CYCLE: assert property (stall |=> !stall)
    else $error("load-use stall longer than one cycle");
  AST_FETCH_ON_ENTER: assert property (s_q.id_v && running && !stall &&
      !flush |-> fetch_req ##1 (ex_valid &&
      ex_pc == $past(s_q.id_pc)))
    else $error("no fetch while entering execute");
  AST_DUAL_PORT: assert property (s_q.ex_v && (s_q.ex_load ||
      s_q.ex_store) && !flush |=> dmem_req &&
      dmem_addr == $past(ex_addr_in) &&
      (fetch_req || stall || flush))
    else $error("fetch blocked by data access");
  AST_STEP: assert property (fetch_req |=> fetch_addr ==
      $past(fetch_addr) + ($past(compact_mode) ? `STEP_HALF : `STEP_WORD))
    else $error("fetch address step wrong");
  AST_STAGES: assert property (seq_enter_mem ##0 seq_no_abort ##0
      s_q.mem_load |=> s_q.wb_load_en)
    else $error("load lost between memory and write");
  AST_PABT: assert property (s_q.ex_v && s_q.ex_abt && !dabt |=>
      exc_take && exc_vector == `VEC_PABT)
    else $error("fetch abort not taken in execute");
  AST_NO_EARLY_PABT: assert property (exc_take && exc_vector == `VEC_PABT
      |-> $past(s_q.ex_v && s_q.ex_abt))
    else $error("fetch abort taken outside execute");
  AST_RESTORE: assert property (dabt && s_q.mem_bwb |=> base_restore_en
      && base_restore_val == $past(s_q.mem_old_base) && !wb_base_en)
    else $error("base not restored on data abort");
  AST_PC_STORE: assert property (s_q.ex_v && s_q.ex_spc && !flush |=>
      dmem_wdata == $past(s_q.ex_pc) + `PC_STORE_OFS)
    else $error("stored pc value wrong");
  AST_UNDEF: assert property (s_q.ex_v && s_q.ex_undef && !s_q.ex_abt &&
      !dabt |=> exc_take && exc_vector == `VEC_UNDEF)
    else $error("undefined instruction not trapped");
  AST_UNDEF_DEC: assert property (s_q.id_v && !s_q.id_abt && d_undef &&
      !stall && !flush |=> s_q.ex_undef)
    else $error("undefined encoding not carried to execute");

endmodule

// ### core_mem_model.sv
// Instruction and data memory model facing the pipeline control
module core_mem_model (
  // Clock
  input  wire logic        sys_clk,
  // Instruction side
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  output logic [31:0]      instr_rdata,
  output logic             fetch_abort_in,
  input  wire logic [31:0] iabt_addr,
  // Data side
  input  wire logic        dmem_req,
  input  wire logic [31:0] dmem_addr,
  output logic             dmem_abort_in,
  input  wire logic [31:0] dabt_addr,
  // Datapath values for the instruction in execute
  input  wire logic [31:0] ex_pc,
  output logic [31:0]      ex_addr_in,
  output logic [31:0]      ex_store_data_in,
  output logic [31:0]      ex_base_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] prog [0:63];

  // Known bus before the first fetch
  initial begin
    instr_rdata = 32'h0000_0000;
    fetch_abort_in = 1'b0;
  end

  // word and abort one cycle after request
  always @(posedge sys_clk) begin
    if (fetch_req) begin
      instr_rdata <= prog[fetch_addr[7:2]];
      fetch_abort_in <= (fetch_addr === iabt_addr);
    end else begin
      instr_rdata <= ~instr_rdata;  // Idle bus keeps moving
      fetch_abort_in <= 1'b0;
    end
  end

  // data side answers in the same cycle
  assign dmem_abort_in = dmem_req && (dmem_addr === dabt_addr);
  // Address and base derived from the address in execute; store data is fixed
  assign ex_addr_in = ex_pc + 32'h0000_1000;
  assign ex_base_in = ex_pc ^ 32'h0000_5a00;
  assign ex_store_data_in = 32'h1234_5678;
endmodule

// ### five_stage_core_pipeline_tb.sv
// Self-checking bench for the five-stage pipeline control
`include "core_pipe_defs.svh"
module five_stage_core_pipeline_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, nrst, compact_mode, fetch_req, fetch_abort_in;
  logic [31:0] st_addr;
  logic [31:0] fetch_addr, instr_rdata, ex_addr_in, ex_store_data_in;
  logic [31:0] ex_base_in, dmem_addr, dmem_wdata, ex_pc, exc_vector;
  logic [31:0] base_restore_val, iabt, dabt, st_data, rest_val, fa [0:3];
  logic        dmem_req, dmem_write, dmem_abort_in, load_use_stall;
  logic        ex_valid, wb_load_en, wb_base_en, base_restore_en, exc_take;
  logic [15:0] wb_load_list, wbl_list;
  logic [3:0]  wb_base_reg, base_restore_reg, rest_reg, wbb_reg;
  int errors, checked, cyc, nf, n_stall, n4, nc, n10, n_rest, n_wbb, n_wbl;
  int n_st, ex0, ex4;

  core_pipe_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .compact_mode(compact_mode), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr),
    .instr_rdata(instr_rdata), .fetch_abort_in(fetch_abort_in),
    .ex_addr_in(ex_addr_in), .ex_store_data_in(ex_store_data_in),
    .ex_base_in(ex_base_in), .dmem_req(dmem_req), .dmem_write(dmem_write),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_abort_in(dmem_abort_in), .load_use_stall(load_use_stall),
    .ex_valid(ex_valid), .ex_pc(ex_pc), .wb_load_en(wb_load_en),
    .wb_load_list(wb_load_list), .wb_base_en(wb_base_en),
    .wb_base_reg(wb_base_reg), .base_restore_en(base_restore_en),
    .base_restore_reg(base_restore_reg),
    .base_restore_val(base_restore_val), .exc_take(exc_take),
    .exc_vector(exc_vector));

  core_mem_model u_mem (.sys_clk(sys_clk), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .instr_rdata(instr_rdata),
    .fetch_abort_in(fetch_abort_in), .iabt_addr(iabt),
    .dmem_req(dmem_req), .dmem_addr(dmem_addr),
    .dmem_abort_in(dmem_abort_in), .dabt_addr(dabt), .ex_pc(ex_pc),
    .ex_addr_in(ex_addr_in), .ex_store_data_in(ex_store_data_in),
    .ex_base_in(ex_base_in));

  // Free-running core clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Event monitor on the falling edge
  always @(negedge sys_clk) begin
    if (nrst === 1'b1) begin
      cyc++;
      if (fetch_req === 1'b1 && nf < 4) begin
        fa[nf] = fetch_addr;
        nf++;
      end
      if (load_use_stall === 1'b1) n_stall++;
      if (exc_take === 1'b1 && exc_vector === `VEC_UNDEF) n4++;
      if (exc_take === 1'b1 && exc_vector === `VEC_PABT) nc++;
      if (exc_take === 1'b1 && exc_vector === `VEC_DABT) n10++;
      if (base_restore_en === 1'b1) begin
        n_rest++;
        rest_reg = base_restore_reg;
        rest_val = base_restore_val;
      end
      if (wb_base_en === 1'b1) begin
        n_wbb++;
        wbb_reg = wb_base_reg;
      end
      if (wb_load_en === 1'b1) begin
        n_wbl++;
        wbl_list = wb_load_list;
      end
      if (dmem_req === 1'b1 && dmem_write === 1'b1) begin
        n_st++;
        st_data = dmem_wdata;
        st_addr = dmem_addr;
      end
      if (ex_valid === 1'b1 && ex_pc === 32'h0 && ex0 < 0) ex0 = cyc;
      if (ex_valid === 1'b1 && ex_pc === 32'h4 && ex4 < 0) ex4 = cyc;
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Hold reset, load a blank program and set abort addresses
  task automatic prep(input logic thm, input logic [31:0] ia, da);
    @(posedge sys_clk);
    nrst <= 1'b0;
    compact_mode <= thm;
    iabt <= ia;
    dabt <= da;
    for (int i = 0; i < 64; i++) u_mem.prog[i] = 32'he1a0_0000;
    repeat (10) @(posedge sys_clk);
  endtask

  // Release reset and check the start-up fetch timing
  task automatic go();
    check("fetch_req in reset", {31'h0, fetch_req}, 32'h0);
    {cyc, nf, n_stall, n4, nc, n10, n_rest, n_wbb, n_wbl, n_st} = '0;
    {wbl_list, wbb_reg, rest_reg, rest_val, st_data, st_addr} = '0;
    ex0 = -1;
    ex4 = -1;
    nrst <= 1'b1;
    @(negedge sys_clk);
    check("fetch_req first", {31'h0, fetch_req}, 32'h0);
    @(negedge sys_clk);
    check("fetch_req second", {31'h0, fetch_req}, 32'h1);
    check("first fetch_addr", fetch_addr, `RESET_PC);
  endtask

  task automatic t_fetch();
    for (int m = 0; m < 2; m++) begin
      prep(m[0], 32'hffff_fff0, 32'hffff_fff0);
      go();
      repeat (8) @(negedge sys_clk);
      for (int k = 0; k < 4; k++)
        check("fetch step", fa[k], k * (m ? 2 : 4));
      if (m == 0) check("execute entry cycle", ex0, 5);
      if (m == 0) check("execute spacing", ex4 - ex0, 1);
    end
    $display("fetch test done");
  endtask

  task automatic t_load_use();
    for (int d = 0; d < 2; d++) begin
      prep(1'b0, 32'hffff_fff0, 32'hffff_fff0);
      u_mem.prog[0] = 32'he597_0000;
      u_mem.prog[1] = d ? 32'he082_5001 : 32'he080_5001;
      go();
      repeat (12) @(negedge sys_clk);
      check("stall count", n_stall, d ? 0 : 1);
      check("execute gap", ex4 - ex0, d ? 1 : 2);
      check("load list", wbl_list, 32'h1);
    end
    $display("load-use test done");
  endtask

  task automatic t_pc_store();
    logic [31:0] op [0:2] = '{32'he581_f000, 32'he4a1_f000, 32'he881_8000};
    for (int k = 0; k < 3; k++) begin
      prep(1'b0, 32'hffff_fff0, 32'hffff_fff0);
      u_mem.prog[2] = op[k];
      go();
      repeat (14) @(negedge sys_clk);
      check("store count", n_st, 1);
      check("stored pc", st_data, 32'h8 + `PC_STORE_OFS);
      check("store addr", st_addr, 32'h0000_1008);
    end
    $display("pc store test done");
  endtask

  task automatic t_undef();
    logic [31:0] op [0:3] = '{32'he600_0010, 32'he7f0_00f0, 32'he040_0090,
                              32'he1a0_0000};
    for (int k = 0; k < 4; k++) begin
      prep(1'b0, 32'hffff_fff0, 32'hffff_fff0);
      u_mem.prog[0] = op[k];
      go();
      repeat (10) @(negedge sys_clk);
      check("undef traps", n4, k < 3);
    end
    $display("undefined test done");
  endtask

  task automatic t_fetch_abort();
    prep(1'b0, 32'h0000_0008, 32'hffff_fff0);
    go();
    repeat (14) @(negedge sys_clk);
    check("fetch abort taken", nc, 1);
    prep(1'b0, 32'h0000_0028, 32'hffff_fff0);
    u_mem.prog[8] = 32'he600_0010;
    go();
    repeat (30) @(negedge sys_clk);
    check("flushed abort ignored", nc, 0);
    check("undef ahead of it", n4 > 0, 1);
    $display("fetch abort test done");
  endtask

  task automatic t_dabt();
    for (int a = 0; a < 2; a++) begin
      prep(1'b0, 32'hffff_fff0, a ? 32'h0000_1000 : 32'hffff_fff0);
      u_mem.prog[0] = 32'he5b7_0004;
      go();
      repeat (12) @(negedge sys_clk);
      check("data abort", n10, a);
      check("base write-back", n_wbb, 1 - a);
      check("load write-back", n_wbl, 1 - a);
      check("restore", n_rest, a);
      if (a == 0) check("base reg", wbb_reg, 32'h7);
      if (a == 1) check("restore reg", rest_reg, 32'h7);
      if (a == 1) check("restore value", rest_val, 32'h5a00);
    end
    $display("data abort test done");
  endtask

  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    compact_mode = 1'b0;
    iabt = 32'hffff_fff0;
    dabt = 32'hffff_fff0;
    errors = 0;
    checked = 0;
    t_fetch();
    t_load_use();
    t_pc_store();
    t_undef();
    t_fetch_abort();
    t_dabt();
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end
endmodule
